/* File: design/ubi_bulk_irq_status.sv */
// bulk endpoint interrupt status registers with an axi4-lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module ubi_bulk_irq_status #(
  parameter int unsigned ADDR_W = ubi_pkg::ADDR_W
) (
  input  wire logic              core_clk_in,
  input  wire logic              resetn_in,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // link side
  input  wire logic [1:0]        cur_interface_in,
  input  wire logic              ep1_in_token_in,
  input  wire logic              ep1_tx_acked_in,
  input  wire logic [3:0]        bo_event_in,
  output logic                   ep1_nak_out,
  output logic                   ep1_tx_send_out,
  output logic                   ep1_fifo_wr_out,
  output logic [7:0]             ep1_fifo_wdata_out,
  output logic                   usb_endpoint_irq_out
);

  // =====================================================================
  // state
  logic [ADDR_W-1:0]        aw_addr;
  logic [7:0]               w_data;
  logic                     w_lane0;
  logic [7:0]               bulk_in_irq_status;
  logic [7:0]               bulk_out_irq_status;
  logic [15:0]              irq_mask;
  ubi_pkg::ubi_map_t        ep_map;
  ubi_pkg::ubi_ep1_state_t  ep1_state;
  ubi_pkg::ubi_ep1_state_t  next_ep1_state;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // =====================================================================
  // write decode
  wire wr_fire    = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  wire wr_bi_stat = hit(aw_addr, ubi_pkg::BI_STAT_ADDR);
  wire wr_bo_stat = hit(aw_addr, ubi_pkg::BO_STAT_ADDR);
  wire wr_bi_clr  = hit(aw_addr, ubi_pkg::BI_CLR_ADDR);
  wire wr_bo_clr  = hit(aw_addr, ubi_pkg::BO_CLR_ADDR);
  wire wr_mask    = hit(aw_addr, ubi_pkg::IRQ_MASK_ADDR);
  wire wr_map     = hit(aw_addr, ubi_pkg::EP_MAP_ADDR);
  wire wr_fifo    = hit(aw_addr, ubi_pkg::EP1_FIFO_ADDR);
  wire wr_nak     = hit(aw_addr, ubi_pkg::EP1_NAK_ADDR);
  wire wr_known   = wr_bi_clr | wr_bo_clr | wr_mask | wr_map | wr_fifo | wr_nak;
  // byte registers act only when their byte lane is written as a whole
  wire wr_ok      = wr_fire && wr_known && w_lane0;
  wire [1:0] wr_resp = (wr_known && !wr_bi_stat && !wr_bo_stat) ?
                       ubi_pkg::RESP_OKAY : ubi_pkg::RESP_SLVERR;
  wire fifo_write = wr_ok && wr_fifo;
  wire arm_write  = wr_ok && wr_nak && w_data[0];

  // =====================================================================
  // read decode
  wire rd_fire    = s_axi_arvalid_in && s_axi_arready_out;
  wire rd_bi_stat = hit(s_axi_araddr_in, ubi_pkg::BI_STAT_ADDR);
  wire rd_bo_stat = hit(s_axi_araddr_in, ubi_pkg::BO_STAT_ADDR);
  wire rd_clr     = hit(s_axi_araddr_in, ubi_pkg::BI_CLR_ADDR) |
                    hit(s_axi_araddr_in, ubi_pkg::BO_CLR_ADDR);
  wire rd_mask    = hit(s_axi_araddr_in, ubi_pkg::IRQ_MASK_ADDR);
  wire rd_map     = hit(s_axi_araddr_in, ubi_pkg::EP_MAP_ADDR);
  wire rd_nak     = hit(s_axi_araddr_in, ubi_pkg::EP1_NAK_ADDR);
  wire rd_known   = rd_bi_stat | rd_bo_stat | rd_clr | rd_mask | rd_map | rd_nak;

  // =====================================================================
  // endpoint validity against the current interface
  wire ep1_valid = ep_map.ep1_en && (ep_map.ep1_iface == cur_interface_in);
  wire ep2_valid = ep_map.ep2_en && (ep_map.ep2_iface == cur_interface_in);
  // invalid endpoints read as zero and cannot raise the line
  wire [7:0] bi_vis = bulk_in_irq_status & {8{ep1_valid}};
  wire [7:0] bo_vis = bulk_out_irq_status & {8{ep2_valid}};

  wire [31:0] rd_data =
    rd_bi_stat ? {24'h0, bi_vis} :
    rd_bo_stat ? {24'h0, bo_vis} :
    rd_clr     ? {24'h0, ubi_pkg::CLR_READ_VAL} :
    // the bus is byte wide; writes load both mask bytes, but the upper one resets to 0F, not 30
    rd_mask    ? {24'h0, irq_mask[7:0]} :
    rd_map     ? {26'h0, ep_map} :
    rd_nak     ? {31'h0, (ep1_state != ubi_pkg::EP1_IDLE)} : 32'h0;

  // =====================================================================
  // endpoint 1 transmit sequence
  wire token_nak  = ep1_in_token_in && (ep1_state != ubi_pkg::EP1_READY) &&
                    (ep1_state != ubi_pkg::EP1_BUSY);
  wire token_send = ep1_in_token_in && (ep1_state == ubi_pkg::EP1_READY);
  // zero-length packets toggle the fifo just like full ones
  wire fifo_toggle = ep1_tx_acked_in && (ep1_state == ubi_pkg::EP1_BUSY);

  always_comb begin
    next_ep1_state = ep1_state;
    case (ep1_state)
      ubi_pkg::EP1_IDLE:  if (arm_write) next_ep1_state = ubi_pkg::EP1_ARMED;
      // the arming token is still answered with nak; data leaves on the next one
      ubi_pkg::EP1_ARMED: if (ep1_in_token_in) next_ep1_state = ubi_pkg::EP1_READY;
      ubi_pkg::EP1_READY: if (token_send) next_ep1_state = ubi_pkg::EP1_BUSY;
      ubi_pkg::EP1_BUSY:  if (ep1_tx_acked_in) next_ep1_state = ubi_pkg::EP1_IDLE;
      default:            next_ep1_state = ubi_pkg::EP1_IDLE;
    endcase
  end

  // =====================================================================
  // status bits: set wins over every clear
  wire       rd_clr_bi = rd_fire && rd_bi_stat;
  wire       rd_clr_bo = rd_fire && rd_bo_stat;
  wire [7:0] bi_clr_n  = (wr_ok && wr_bi_clr) ? w_data : 8'hFF;
  wire [7:0] bo_clr_n  = (wr_ok && wr_bo_clr) ? w_data : 8'hFF;
  wire [7:0] bi_set;
  assign bi_set[7:6] = 2'h0;
  assign bi_set[5]   = token_nak && ep1_valid;
  assign bi_set[4]   = fifo_toggle && ep1_valid;
  assign bi_set[3:0] = 4'h0;
  wire [7:0] bi_keep = bulk_in_irq_status & bi_clr_n & {8{!rd_clr_bi}} &
                       {3'h7, !fifo_write, 4'hF};
  wire [7:0] next_bulk_in_irq_status =
    (bi_set | bi_keep) & ubi_pkg::BI_USED_MASK;
  wire [7:0] bo_keep = bulk_out_irq_status & bo_clr_n & {8{!rd_clr_bo}};
  wire [7:0] next_bulk_out_irq_status =
    ({4'h0, bo_event_in & {4{ep2_valid}}} | bo_keep) & ubi_pkg::BO_USED_MASK;

  // any unmasked status bit of a valid endpoint left standing holds the line
  wire next_irq = |({bo_vis, bi_vis} & irq_mask);

  // =====================================================================
  // registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bulk_in_irq_status  <= ubi_pkg::STAT_RST;
      bulk_out_irq_status <= ubi_pkg::STAT_RST;
      irq_mask            <= ubi_pkg::IRQ_MASK_RST;
      ep_map              <= ubi_pkg::MAP_RST;
      ep1_state           <= ubi_pkg::EP1_IDLE;
      usb_endpoint_irq_out <= 1'b0;
    end else begin
      bulk_in_irq_status  <= next_bulk_in_irq_status;
      bulk_out_irq_status <= next_bulk_out_irq_status;
      ep1_state           <= next_ep1_state;
      usb_endpoint_irq_out <= next_irq;
      if (wr_ok && wr_mask) irq_mask <= {w_data, irq_mask[7:0]};
      if (wr_ok && wr_mask) irq_mask[7:0] <= w_data;
      if (wr_ok && wr_map) ep_map <= w_data[ubi_pkg::MAP_W-1:0];
    end
  end

  // link pulses
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ep1_nak_out        <= 1'b0;
      ep1_tx_send_out    <= 1'b0;
      ep1_fifo_wr_out    <= 1'b0;
      ep1_fifo_wdata_out <= 8'h00;
    end else begin
      ep1_nak_out     <= token_nak || (ep1_in_token_in && ep1_state == ubi_pkg::EP1_BUSY);
      ep1_tx_send_out <= token_send;
      ep1_fifo_wr_out <= fifo_write;
      if (fifo_write) ep1_fifo_wdata_out <= w_data;
    end
  end

  // =====================================================================
  // axi write channels: address and data taken in either order
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= ubi_pkg::RESP_OKAY;
      aw_addr           <= '0;
      w_data            <= 8'h00;
      w_lane0           <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        s_axi_awready_out <= 1'b0;
        aw_addr           <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        s_axi_wready_out <= 1'b0;
        w_data           <= s_axi_wdata_in[7:0];
        w_lane0          <= s_axi_wstrb_in[0];
      end else if (wr_fire) begin
        s_axi_wready_out <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_resp;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // axi read channel, one read in flight
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= ubi_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_data;
      s_axi_rresp_out   <= rd_known ? ubi_pkg::RESP_OKAY : ubi_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

endmodule : ubi_bulk_irq_status

/* File: design/ubi_pkg.sv */
// constants, field layouts and carrier types of the bulk endpoint interrupt status block
//
// Notes on behaviour
// - the endpoint interrupt line asserts while any unmasked, valid bit of either bulk status register is set.
// - both status registers are read-only and are used only as whole bytes.
// - writing 0 to a bulk-in clear bit clears that status bit; 1 leaves it.
// - writing 0 to a bulk-out clear bit clears that status bit.
// - bulk-in bits are invalid unless endpoint 1 maps to the current interface.
// - bulk-out bits are invalid unless endpoint 2 maps to the current interface.
// - bulk-in status sits at index FF29, resets to 00, bits 7,6,3..0 read zero.
// - bulk-in bit 5 sets when an endpoint 1 IN token is answered with NAK, except a NAK given in EP1_BUSY.
// - bulk-in bit 4 sets when the endpoint 1 FIFO toggled and may be refilled.
// - the FIFO-toggled flag also sets after a zero-length packet toggles the FIFO.
// - the FIFO-toggled flag clears on the first CPU write to the transmit FIFO.
package ubi_pkg;

  // =====================================================================
  // register indices and byte addresses
  localparam int unsigned         ADDR_W          = 20;
  localparam logic [15:0]         BI_STAT_IDX     = 16'hFF29;
  localparam logic [15:0]         BO_STAT_IDX     = 16'hFF2A;
  localparam logic [15:0]         BI_CLR_IDX      = 16'hFF2B;
  localparam logic [15:0]         BO_CLR_IDX      = 16'hFF2C;
  localparam logic [15:0]         IRQ_MASK_IDX    = 16'hFF2D;
  localparam logic [15:0]         EP_MAP_IDX      = 16'hFF2E;
  localparam logic [15:0]         EP1_FIFO_IDX    = 16'hFF2F;
  localparam logic [15:0]         EP1_NAK_IDX     = 16'hFF30;
  localparam logic [ADDR_W-1:0]   BI_STAT_ADDR    = {2'h0, BI_STAT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   BO_STAT_ADDR    = {2'h0, BO_STAT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   BI_CLR_ADDR     = {2'h0, BI_CLR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   BO_CLR_ADDR     = {2'h0, BO_CLR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   IRQ_MASK_ADDR   = {2'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   EP_MAP_ADDR     = {2'h0, EP_MAP_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   EP1_FIFO_ADDR   = {2'h0, EP1_FIFO_IDX, 2'h0};
  localparam logic [ADDR_W-1:0]   EP1_NAK_ADDR    = {2'h0, EP1_NAK_IDX, 2'h0};

  // =====================================================================
  // field positions and reset values
  localparam int unsigned         BI_NAK_BIT      = 5;
  localparam int unsigned         BI_TOG_BIT      = 4;
  localparam logic [7:0]          BI_USED_MASK    = 8'h30;
  localparam logic [7:0]          BO_USED_MASK    = 8'h0F;
  localparam logic [7:0]          STAT_RST        = 8'h00;
  localparam logic [15:0]         IRQ_MASK_RST    = 16'h0F30;
  localparam logic [7:0]          CLR_READ_VAL    = 8'hFF;
  localparam logic [1:0]          RESP_OKAY       = 2'h0;
  localparam logic [1:0]          RESP_SLVERR     = 2'h2;

  // endpoint to interface mapping, six bits in one byte register
  typedef struct packed {
    logic [1:0] ep2_iface;
    logic       ep2_en;
    logic [1:0] ep1_iface;
    logic       ep1_en;
  } ubi_map_t;
  localparam int unsigned         MAP_W           = 6;
  localparam logic [MAP_W-1:0]    MAP_RST         = 6'h00;

  // endpoint 1 transmit sequencing
  typedef enum logic [1:0] {
    EP1_IDLE  = 2'b00,
    EP1_ARMED = 2'b01,
    EP1_READY = 2'b10,
    EP1_BUSY  = 2'b11
  } ubi_ep1_state_t;

endpackage : ubi_pkg

/* File: test/ubi_host_model.sv */
// host-side model: issues endpoint 1 IN tokens and acks sent packets
`timescale 1ns/1ps
module ubi_host_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       tok_req_in,
  input  wire logic [3:0] ack_dly_in,
  input  wire logic       send_in,
  output logic            token_out,
  output logic            acked_out,
  output logic [3:0]      sends_out
);
  logic [3:0] cnt;
  logic       busy;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      {token_out, acked_out, busy, cnt, sends_out} <= '0;
    end else begin
      token_out <= tok_req_in;
      acked_out <= busy && cnt == 4'h0;
      busy      <= send_in || (busy && cnt != 4'h0);
      cnt       <= send_in ? ack_dly_in : cnt - {3'h0, cnt != 4'h0};
      sends_out <= sends_out + {3'h0, send_in};
    end
  end
endmodule : ubi_host_model

/* File: test/ubi_bulk_irq_status_properties.sv */
// concurrent checks on the ports of the bulk endpoint interrupt status block
`timescale 1ns/1ps
module ubi_checker (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        ep1_in_token_in,
  input wire logic        ep1_tx_acked_in,
  input wire logic [3:0]  bo_event_in,
  input wire logic        ep1_nak_out,
  input wire logic        ep1_tx_send_out,
  input wire logic        usb_endpoint_irq_out
);
  // =====================================
  // cause windows, slack so latency choices do not trip them
  logic [2:0] ev_cnt;
  logic [2:0] cpu_cnt;
  wire        ev_hit  = ep1_in_token_in | ep1_tx_acked_in | (|bo_event_in) | s_axi_bvalid_out;
  wire        cpu_hit = s_axi_rvalid_out | s_axi_bvalid_out;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ev_cnt  <= 3'h0;
      cpu_cnt <= 3'h0;
    end else begin
      ev_cnt  <= ev_hit ? 3'h4 : ev_cnt - {2'h0, ev_cnt != 3'h0};
      cpu_cnt <= cpu_hit ? 3'h4 : cpu_cnt - {2'h0, cpu_cnt != 3'h0};
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // =====================================
  // assertions
  irq_rise_a: assert property ($rose(usb_endpoint_irq_out) |-> ev_cnt != 3'h0)
    else $error("interrupt rose with no status event");
  irq_fall_a: assert property ($fell(usb_endpoint_irq_out) |-> cpu_cnt != 3'h0)
    else $error("interrupt fell with no cpu access");
  bresp_ack_a: assert property ($fell(s_axi_bvalid_out) |-> $past(s_axi_bready_in))
    else $error("write response dropped before accepted");
  rdata_ack_a: assert property ($fell(s_axi_rvalid_out) |-> $past(s_axi_rready_in))
    else $error("read data dropped before accepted");
  read_cause_a: assert property ($rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in))
    else $error("read data with no request");
  byte_wide_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data beyond one byte");
  nak_cause_a: assert property (ep1_nak_out |-> $past(ep1_in_token_in) && !ep1_tx_send_out)
    else $error("nak pulse without token");
  send_once_a: assert property (
    ep1_tx_send_out && !ep1_in_token_in |=> !ep1_tx_send_out && !ep1_nak_out)
    else $error("send pulse too long");
endmodule : ubi_checker
bind ubi_bulk_irq_status ubi_checker u_checker (.*);

/* File: test/tb_usb_bulk_ep_irq_status.sv */
// self-checking bench for the bulk endpoint interrupt status block
`timescale 1ns/1ps
module tb_usb_bulk_ep_irq_status;
  typedef struct packed {logic wr; logic [19:0] a; logic [7:0] d; logic [1:0] r;} ubi_row_t;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, tokq = 1'h0;
  logic [19:0] awa = 20'h0, ara = 20'h0;
  logic [31:0] wd = 32'h0;
  logic [1:0]  cur = 2'h0;
  logic [3:0]  bo = 4'h0, dly = 4'h0;
  logic        awr, wrdy, bv, arr, rv, tok_w, ack_w, snd, fwr, irq, nak;
  int          naks = 0;
  logic [1:0]  bres, rres;
  logic [31:0] rdat;
  logic [7:0]  fwd, fbyte;
  logic [3:0]  sends;
  int          errors = 0;
  int          cmp_count = 0;
  ubi_row_t    rows[6] = '{
    '{1'h0, ubi_pkg::BI_STAT_ADDR, 8'h00, ubi_pkg::RESP_OKAY},
    '{1'h0, ubi_pkg::BO_STAT_ADDR, 8'h00, ubi_pkg::RESP_OKAY},
    '{1'h0, ubi_pkg::BI_CLR_ADDR, 8'hFF, ubi_pkg::RESP_OKAY},
    '{1'h0, ubi_pkg::EP_MAP_ADDR, 8'h00, ubi_pkg::RESP_OKAY},
    '{1'h0, 20'h00000, 8'h00, ubi_pkg::RESP_SLVERR},
    '{1'h1, ubi_pkg::BI_STAT_ADDR, 8'h30, ubi_pkg::RESP_SLVERR}};
  always #12.5 clk = ~clk;
  always @(posedge clk) if (fwr) fbyte <= fwd;
  always @(posedge clk) if (nak) naks <= naks + 1;
  ubi_bulk_irq_status DUT (
    .core_clk_in(clk), .resetn_in(rstn), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(bres),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rres), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .cur_interface_in(cur), .ep1_in_token_in(tok_w), .ep1_tx_acked_in(ack_w),
    .bo_event_in(bo), .ep1_nak_out(nak), .ep1_tx_send_out(snd), .ep1_fifo_wr_out(fwr),
    .ep1_fifo_wdata_out(fwd), .usb_endpoint_irq_out(irq));
  ubi_host_model host (.clk_in(clk), .resetn_in(rstn), .tok_req_in(tokq), .ack_dly_in(dly),
    .send_in(snd), .token_out(tok_w), .acked_out(ack_w), .sends_out(sends));
  // =====================================
  // bus and event tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input ubi_row_t t);
    int n;
    n = 0;
    awa <= t.a;
    ara <= t.a;
    wd  <= {24'h0, t.d};
    awv <= t.wr;
    wv  <= t.wr;
    bry <= t.wr;
    arv <= !t.wr;
    rry <= !t.wr;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      if (arr) arv <= 1'h0;
      n++;
    end while (!(t.wr ? bv : rv) && n < 40);
    bry <= 1'h0;
    rry <= 1'h0;
    check({30'h0, t.wr ? bres : rres}, {30'h0, t.r});
    if (!t.wr) check(rdat, {24'h0, t.d});
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [19:0] a, input logic [7:0] d);
    xfer('{1'h0, a, d, ubi_pkg::RESP_OKAY});
  endtask : rd
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    xfer('{1'h1, a, d, ubi_pkg::RESP_OKAY});
  endtask : wr
  // one token request and/or bulk-out event pulse, then let them settle
  task automatic ev(input logic t, input logic [3:0] b);
    tokq <= t;
    bo   <= b;
    @(posedge clk);
    tokq <= 1'h0;
    bo   <= 4'h0;
    repeat (6) @(posedge clk);
  endtask : ev
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // =====================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    foreach (rows[i]) xfer(rows[i]);
    ev(1'h1, 4'hF);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h00);
    wr(ubi_pkg::EP_MAP_ADDR, 8'h09);
    ev(1'h1, 4'h0);
    check({31'h0, irq}, 32'h1);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h20);
    check({31'h0, irq}, 32'h0);
    ev(1'h1, 4'h0);
    wr(ubi_pkg::BI_CLR_ADDR, 8'hFF);
    check({31'h0, irq}, 32'h1);
    wr(ubi_pkg::BI_CLR_ADDR, 8'hDF);
    check({31'h0, irq}, 32'h0);
    // null packet with a prompt ack, then a data packet with a slow ack
    for (int k = 1; k <= 2; k++) begin
      if (k == 2) wr(ubi_pkg::EP1_FIFO_ADDR, 8'hA5);
      wr(ubi_pkg::EP1_NAK_ADDR, 8'h01);
      ev(1'h1, 4'h0);
      ev(1'h1, 4'h0);
      repeat (12) @(posedge clk);
      check({28'h0, sends}, k);
      dly <= 4'h9;
    end
    check({24'h0, fbyte}, 32'hA5);
    wr(ubi_pkg::BI_CLR_ADDR, 8'hDF);
    check({31'h0, irq}, 32'h1);
    wr(ubi_pkg::EP1_FIFO_ADDR, 8'h3C);
    check({31'h0, irq}, 32'h0);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h00);
    ev(1'h0, 4'h5);
    wr(ubi_pkg::BO_CLR_ADDR, 8'hFE);
    rd(ubi_pkg::BO_STAT_ADDR, 8'h04);
    wr(ubi_pkg::IRQ_MASK_ADDR, 8'h00);
    ev(1'h1, 4'h0);
    check({31'h0, irq}, 32'h0);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h20);
    wr(ubi_pkg::EP_MAP_ADDR, 8'h01);
    cur <= 2'h1;
    ev(1'h1, 4'hF);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h00);
    rd(ubi_pkg::BO_STAT_ADDR, 8'h00);
    // every token outside the send slot was answered with nak
    check(naks, 32'h7);
    // =====================================
    // reset in mid-run: registers back to their reset values
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    cur  <= 2'h0;
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h00);
    rd(ubi_pkg::IRQ_MASK_ADDR, 8'h30);
    rd(ubi_pkg::EP_MAP_ADDR, 8'h00);
    ev(1'h1, 4'hF);
    rd(ubi_pkg::BI_STAT_ADDR, 8'h00);
    rd(ubi_pkg::BO_STAT_ADDR, 8'h00);
    wrap_up();
  end
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : tb_usb_bulk_ep_irq_status
